//--- sdid_decoder.sv
// digital input decoder: synchronisers, function mapping, command decode, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sdid_defines.svh"

// Summary of operation
// - full variant has inputs 0 to 9; reduced variant only inputs 2 to 7
// - every input readable; software maps each function to any input
// - servo-enable rising edge switches power stage on, converter ready
// - servo-enable falling edge: ramp stop, but coast stop in torque mode
// - fault-acknowledge rising edge resets pending faults in every mode
// - limits and emergency stop high permit running; limit fall or stop low quick-stops
// - gain-switch low selects factor 1/PI, high factor 2/P; position, speed
// - pulse-inhibit high blocks pulse setpoint, pulse position mode only
// - droop-clear high clears droop per configured mode, pulse mode only
// - two gear bits pick one of four gear ratios in position mode
// - two bits pick torque limit 0 to 3 in position and speed modes
// - two bits pick speed limit 0 to 3 in every mode
// - clockwise enable high runs with ramp up, low stops with ramp down
// - counterclockwise enable: high enables with ramp down, low ramps up
// - zero hold high with analog setpoint below threshold clamps in speed mode
// - three bits pick analog speed setpoint at 000, else fixed 1 to 7
// - torque source low picks analog, high picks fixed torque setpoint
// - mode switch low picks first configured mode, high the second
// - compound configuration: first mode speed, second mode torque
module sdid_decoder #(
  parameter int NUM_INPUTS   = 10,
  parameter bit FULL_VARIANT = 1'b1,
  parameter int SETPOINT_W   = 16
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rstn,
  input  wire logic [NUM_INPUTS-1:0] i_din,
  input  wire logic [SETPOINT_W-1:0] i_analog_speed_mag,
  input  wire logic                  i_analog_speed_used,
  output var  sdid_pkg::sdid_cmd_t   o_cmd,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // elaboration checks: the decode and status layout assume ten inputs
  if (NUM_INPUTS != 10)
    $error("sdid_decoder: NUM_INPUTS must be 10");
  if (SETPOINT_W < 1 || SETPOINT_W > 16)
    $error("sdid_decoder: SETPOINT_W must be 1 to 16");

  // ****************************************************************
  // functions
  // ****************************************************************
  // inputs present on this variant
  function automatic logic [NUM_INPUTS-1:0] present_mask();
    logic [NUM_INPUTS-1:0] m;
    m = '0;
    for (int k = 0; k < NUM_INPUTS; k++)
    begin
      if (FULL_VARIANT || (k >= 2 && k <= 7))
        m[k] = 1'b1;
    end
    return m;
  endfunction

  // level of the input mapped to a function; unmapped reads as its idle level
  function automatic logic pick(input logic [3:0] sel,
                                input logic [NUM_INPUTS-1:0] lvl,
                                input logic idle);
    logic r;
    logic [NUM_INPUTS-1:0] pm;
    r = idle;
    pm = present_mask();
    for (int k = 0; k < NUM_INPUTS; k++)
    begin
      if (sel == 4'(k) && pm[k])
        r = lvl[k];
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r & mask;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == `SDID_ADDR_INPUT_STATUS || a == `SDID_ADDR_CONTROL ||
           a == `SDID_ADDR_THRESHOLD || a == `SDID_ADDR_FSEL0 ||
           a == `SDID_ADDR_FSEL1 || a == `SDID_ADDR_FSEL2 ||
           a == `SDID_ADDR_CMD_STATUS;
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [NUM_INPUTS-1:0] sync1_r;
  logic [NUM_INPUTS-1:0] sync2_r;
  logic [NUM_INPUTS-1:0] sync3_r;
  logic [NUM_INPUTS-1:0] din_r;
  logic [NUM_INPUTS-1:0] din_nxt;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end
    else
    begin
      sync1_r <= i_din;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change counts only once stages two and three agree
  always_comb
  begin
    din_nxt = din_r;
    for (int k = 0; k < NUM_INPUTS; k++)
    begin
      if (sync2_r[k] == sync3_r[k])
        din_nxt[k] = sync2_r[k];
    end
    din_nxt = din_nxt & present_mask();
  end

  // starts low: limits and stop are held off until proven high
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      din_r <= '0;
    else
      din_r <= din_nxt;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] ctl_r;
  logic [31:0] thr_r;
  logic [95:0] fsel_r;

  logic wr_go;
  logic rd_go;
  logic [1:0] bresp_r;
  logic bvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rvalid_r;
  logic [31:0] rd_val;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctl_r <= `SDID_CTL_RST;
      thr_r <= `SDID_THR_RST;
      fsel_r <= {`SDID_FSEL2_RST, `SDID_FSEL1_RST, `SDID_FSEL0_RST};
    end
    else if (wr_go)
    begin
      unique case (s_axi_awaddr)
        `SDID_ADDR_CONTROL:
          ctl_r <= merge(ctl_r, s_axi_wdata, s_axi_wstrb, `SDID_CTL_MASK);
        `SDID_ADDR_THRESHOLD:
          thr_r <= merge(thr_r, s_axi_wdata, s_axi_wstrb, `SDID_THR_MASK);
        `SDID_ADDR_FSEL0:
          fsel_r[31:0] <= merge(fsel_r[31:0], s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
        `SDID_ADDR_FSEL1:
          fsel_r[63:32] <= merge(fsel_r[63:32], s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
        `SDID_ADDR_FSEL2:
          fsel_r[95:64] <= merge(fsel_r[95:64], s_axi_wdata, s_axi_wstrb, `SDID_FSEL2_MASK);
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `SDID_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      // status registers are read-only
      bresp_r <= (addr_mapped(s_axi_awaddr) && s_axi_awaddr != `SDID_ADDR_INPUT_STATUS &&
                  s_axi_awaddr != `SDID_ADDR_CMD_STATUS) ? `SDID_RESP_OKAY : `SDID_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `SDID_ADDR_INPUT_STATUS:
        rd_val = {14'h0000, 6'h00, 2'(o_cmd.active_mode), 10'(din_r)};
      `SDID_ADDR_CONTROL:
        rd_val = ctl_r;
      `SDID_ADDR_THRESHOLD:
        rd_val = thr_r;
      `SDID_ADDR_FSEL0:
        rd_val = fsel_r[31:0];
      `SDID_ADDR_FSEL1:
        rd_val = fsel_r[63:32];
      `SDID_ADDR_FSEL2:
        rd_val = fsel_r[95:64];
      `SDID_ADDR_CMD_STATUS:
        rd_val = 32'(o_cmd);
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SDID_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= addr_mapped(s_axi_araddr) ? `SDID_RESP_OKAY : `SDID_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // ****************************************************************
  // function levels and edges
  // ****************************************************************
  logic [`SDID_FN_COUNT-1:0] fn_idle;
  logic [`SDID_FN_COUNT-1:0] fn_lvl;
  logic [`SDID_FN_COUNT-1:0] fn_prev_r;
  logic [`SDID_FN_COUNT-1:0] fn_rise;
  logic [`SDID_FN_COUNT-1:0] fn_fall;

  // limits and stop idle high so an unmapped one never blocks running
  always_comb
  begin
    fn_idle = '0;
    fn_idle[`SDID_FN_CWL] = 1'b1;
    fn_idle[`SDID_FN_CCW_TRAVEL_LIMIT] = 1'b1;
    fn_idle[`SDID_FN_ESTOP] = 1'b1;
    for (int f = 0; f < `SDID_FN_COUNT; f++)
      fn_lvl[f] = pick(fsel_r[f*4 +: 4], din_r, fn_idle[f]);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      fn_prev_r <= {`SDID_FN_COUNT{1'b0}};
    else
      fn_prev_r <= fn_lvl;
  end

  assign fn_rise = fn_lvl & ~fn_prev_r;
  assign fn_fall = ~fn_lvl & fn_prev_r;

  // ****************************************************************
  // active control mode
  // ****************************************************************
  sdid_pkg::sdid_act_mode_t mode;
  logic pos_m;
  logic spd_m;
  logic trq_m;

  always_comb
  begin
    unique case (ctl_r[`SDID_CTL_MODE_LSB +: `SDID_CTL_MODE_W])
      `SDID_MODE_SPEED:
        mode = sdid_pkg::SDID_ACT_SPEED;
      `SDID_MODE_TORQUE:
        mode = sdid_pkg::SDID_ACT_TORQUE;
      `SDID_MODE_SPD_TRQ:
        mode = fn_lvl[`SDID_FN_CMODE] ? sdid_pkg::SDID_ACT_TORQUE
                                      : sdid_pkg::SDID_ACT_SPEED;
      default:
        mode = sdid_pkg::SDID_ACT_PULSE;
    endcase
  end

  assign pos_m = (mode == sdid_pkg::SDID_ACT_PULSE);
  assign spd_m = (mode == sdid_pkg::SDID_ACT_SPEED);
  assign trq_m = (mode == sdid_pkg::SDID_ACT_TORQUE);

  // ****************************************************************
  // run and stop state
  // ****************************************************************
  logic run_r;
  logic ramp_r;
  logic coast_r;
  logic qstop_r;
  logic permit;
  logic qstop_set;

  assign permit = fn_lvl[`SDID_FN_CWL] && fn_lvl[`SDID_FN_CCW_TRAVEL_LIMIT] && fn_lvl[`SDID_FN_ESTOP];
  assign qstop_set = fn_fall[`SDID_FN_CWL] || fn_fall[`SDID_FN_CCW_TRAVEL_LIMIT] ||
                     !fn_lvl[`SDID_FN_ESTOP];

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      run_r <= 1'b0;
    else if (fn_rise[`SDID_FN_SERVO])
      run_r <= 1'b1;
    else if (fn_fall[`SDID_FN_SERVO])
      run_r <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ramp_r <= 1'b0;
      coast_r <= 1'b0;
    end
    else if (fn_fall[`SDID_FN_SERVO])
    begin
      ramp_r <= !trq_m;
      coast_r <= trq_m;
    end
    else if (fn_rise[`SDID_FN_SERVO])
    begin
      ramp_r <= 1'b0;
      coast_r <= 1'b0;
    end
  end

  // a new stop cause wins over an acknowledge in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      qstop_r <= 1'b0;
    else if (qstop_set)
      qstop_r <= 1'b1;
    else if (fn_rise[`SDID_FN_ACK] && permit)
      qstop_r <= 1'b0;
  end

  // ****************************************************************
  // command outputs
  // ****************************************************************
  sdid_pkg::sdid_cmd_t cmd_nxt;
  logic below_thr;

  assign below_thr = i_analog_speed_used &&
                     (16'(i_analog_speed_mag) < thr_r[15:0]);

  always_comb
  begin
    cmd_nxt = '0;
    cmd_nxt.power_on = run_r && permit && !qstop_r;
    cmd_nxt.ramp_stop = ramp_r;
    cmd_nxt.coast_stop = coast_r;
    cmd_nxt.quick_stop = qstop_r || !permit;
    cmd_nxt.fault_ack = fn_rise[`SDID_FN_ACK];
    cmd_nxt.gain_high = (pos_m || spd_m) && fn_lvl[`SDID_FN_GAIN];
    cmd_nxt.pulse_inhibit = pos_m && fn_lvl[`SDID_FN_PINH];
    cmd_nxt.droop_clear = pos_m && fn_lvl[`SDID_FN_DROOP];
    cmd_nxt.droop_clear_mode = ctl_r[`SDID_CTL_DROOP_LSB +: `SDID_CTL_DROOP_W];
    if (pos_m)
      cmd_nxt.gear_ratio = {fn_lvl[`SDID_FN_GEAR1], fn_lvl[`SDID_FN_GEAR0]};
    if (pos_m || spd_m)
      cmd_nxt.torque_limit_sel = {fn_lvl[`SDID_FN_TL1], fn_lvl[`SDID_FN_TL0]};
    cmd_nxt.speed_limit_sel = {fn_lvl[`SDID_FN_SL1], fn_lvl[`SDID_FN_SL0]};
    if (spd_m || trq_m)
    begin
      cmd_nxt.cw_enable = fn_lvl[`SDID_FN_CWE];
      cmd_nxt.cw_ramp_up = fn_lvl[`SDID_FN_CWE];
      cmd_nxt.ccw_enable = fn_lvl[`SDID_FN_CCW_ROTATION_ENABLE];
      cmd_nxt.ccw_ramp_up = !fn_lvl[`SDID_FN_CCW_ROTATION_ENABLE];
    end
    cmd_nxt.zero_clamp = spd_m && fn_lvl[`SDID_FN_ZHOLD] && below_thr;
    if (spd_m)
      cmd_nxt.speed_source = {fn_lvl[`SDID_FN_FIXED_SPEED_SEL_B2], fn_lvl[`SDID_FN_FIXED_SPEED_SEL_B1],
                              fn_lvl[`SDID_FN_FIXED_SPEED_SEL_B0]};
    cmd_nxt.torque_fixed = trq_m && fn_lvl[`SDID_FN_TSRC];
    cmd_nxt.active_mode = mode;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_cmd <= '0;
    else
      o_cmd <= cmd_nxt;
  end

endmodule

`default_nettype wire

//--- sdid_defines.svh
// offsets, field positions, reset values and codes of the digital input decoder
`ifndef SDID_DEFINES_SVH
`define SDID_DEFINES_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define SDID_ADDR_INPUT_STATUS 8'h00
`define SDID_ADDR_CONTROL      8'h04
`define SDID_ADDR_THRESHOLD    8'h08
`define SDID_ADDR_FSEL0        8'h0c
`define SDID_ADDR_FSEL1        8'h10
`define SDID_ADDR_FSEL2        8'h14
`define SDID_ADDR_CMD_STATUS   8'h18

// ****************************************************************
// control register fields
// ****************************************************************
`define SDID_CTL_MODE_LSB   0
`define SDID_CTL_MODE_W     3
`define SDID_CTL_DROOP_LSB  4
`define SDID_CTL_DROOP_W    2
`define SDID_CTL_MASK       32'h0000_0037
`define SDID_CTL_RST        32'h0000_0000
`define SDID_THR_MASK       32'h0000_ffff
`define SDID_THR_RST        32'h0000_0000

// control mode codes
`define SDID_MODE_PULSE     3'h0
`define SDID_MODE_SPEED     3'h1
`define SDID_MODE_TORQUE    3'h2
`define SDID_MODE_SPD_TRQ   3'h7

// ****************************************************************
// function selectors: one nibble per function, 4'hf = not assigned
// ****************************************************************
`define SDID_FSEL_UNASSIGNED 4'hf
`define SDID_FSEL0_RST      32'h785f_1032
`define SDID_FSEL1_RST      32'hffff_ffff
`define SDID_FSEL2_RST      32'h0096_ffff
`define SDID_FSEL2_MASK     32'h00ff_ffff

`define SDID_FN_SERVO       0
`define SDID_FN_ACK         1
`define SDID_FN_CWL         2
`define SDID_FN_CCW_TRAVEL_LIMIT        3
`define SDID_FN_GAIN        4
`define SDID_FN_PINH        5
`define SDID_FN_DROOP       6
`define SDID_FN_GEAR0       7
`define SDID_FN_GEAR1       8
`define SDID_FN_TL0         9
`define SDID_FN_TL1         10
`define SDID_FN_SL0         11
`define SDID_FN_SL1         12
`define SDID_FN_CWE         13
`define SDID_FN_CCW_ROTATION_ENABLE        14
`define SDID_FN_ZHOLD       15
`define SDID_FN_FIXED_SPEED_SEL_B0        16
`define SDID_FN_FIXED_SPEED_SEL_B1        17
`define SDID_FN_FIXED_SPEED_SEL_B2        18
`define SDID_FN_TSRC        19
`define SDID_FN_ESTOP       20
`define SDID_FN_CMODE       21
`define SDID_FN_COUNT       22

// AXI responses
`define SDID_RESP_OKAY      2'h0
`define SDID_RESP_SLVERR    2'h2

`endif

//--- sdid_pkg.sv
// types of the digital input decoder
package sdid_pkg;

  typedef enum logic [1:0] {
    SDID_ACT_PULSE,
    SDID_ACT_SPEED,
    SDID_ACT_TORQUE
  } sdid_act_mode_t;

  typedef struct packed {
    logic           power_on;
    logic           ramp_stop;
    logic           coast_stop;
    logic           quick_stop;
    logic           fault_ack;
    logic           gain_high;
    logic           pulse_inhibit;
    logic           droop_clear;
    logic [1:0]     droop_clear_mode;
    logic [1:0]     gear_ratio;
    logic [1:0]     torque_limit_sel;
    logic [1:0]     speed_limit_sel;
    logic           cw_enable;
    logic           cw_ramp_up;
    logic           ccw_enable;
    logic           ccw_ramp_up;
    logic           zero_clamp;
    logic [2:0]     speed_source;
    logic           torque_fixed;
    sdid_act_mode_t active_mode;
  } sdid_cmd_t;

endpackage

//--- sdid_dec_properties.sv
// port timing checker of the digital input decoder
`timescale 1ns/1ps
`default_nettype none
module sdid_dec_props (
  input wire logic                i_sys_clk,
  input wire logic                i_rstn,
  input wire sdid_pkg::sdid_cmd_t o_cmd,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // ********
  // bus
  // ********
  property p_wr_ans;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_wr_stall;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write taken while answering");
  property p_rd_ans;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  // ********
  // commands
  // ********
  property p_qs;
    o_cmd.power_on |-> !o_cmd.quick_stop;
  endproperty
  a_qs: assert property (p_qs) else $error("running under quick stop");
  property p_ack;
    $rose(o_cmd.fault_ack) |=> !o_cmd.fault_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack pulse too long");
  property p_pos;
    o_cmd.pulse_inhibit || o_cmd.droop_clear || o_cmd.gear_ratio != 2'h0
      |-> o_cmd.active_mode == sdid_pkg::SDID_ACT_PULSE;
  endproperty
  a_pos: assert property (p_pos) else $error("position field outside mode");
  property p_ramp;
    o_cmd.active_mode != sdid_pkg::SDID_ACT_PULSE
      |-> o_cmd.cw_ramp_up == o_cmd.cw_enable && o_cmd.ccw_ramp_up == !o_cmd.ccw_enable;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp direction wrong");
  property p_spd;
    o_cmd.zero_clamp || o_cmd.speed_source != 3'h0
      |-> o_cmd.active_mode == sdid_pkg::SDID_ACT_SPEED;
  endproperty
  a_spd: assert property (p_spd) else $error("speed field outside mode");
  property p_trq;
    o_cmd.torque_fixed || o_cmd.coast_stop |-> !o_cmd.ramp_stop
      && (o_cmd.coast_stop || o_cmd.active_mode == sdid_pkg::SDID_ACT_TORQUE);
  endproperty
  a_trq: assert property (p_trq) else $error("torque field wrong");
endmodule
bind sdid_decoder sdid_dec_props u_props (.i_sys_clk, .i_rstn, .o_cmd, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

//--- sdid_ctrl_model.sv
// machine controller model driving the digital input lines
`timescale 1ns/1ps
`default_nettype none
module sdid_ctrl_model (
  input  wire logic       i_sys_clk,
  input  wire logic [9:0] i_lvl,
  output logic      [9:0] o_din
);
  // lines move just after an edge, like a clocked output stage
  initial o_din = 10'h000;
  always @(posedge i_sys_clk)
  begin
    o_din <= i_lvl;
  end
endmodule
`default_nettype wire

//--- tb_servo_digital_input_decoder.sv
// self-checking bench of the digital input decoder
`timescale 1ns/1ps
`default_nettype none
`include "sdid_defines.svh"
module tb_servo_digital_input_decoder;
  logic                i_sys_clk;
  logic                i_rstn;
  logic [9:0]          lvl;
  logic [9:0]          i_din;
  logic [15:0]         i_analog_speed_mag;
  logic                i_analog_speed_used;
  sdid_pkg::sdid_cmd_t o_cmd;
  logic [7:0]          s_axi_awaddr;
  logic [7:0]          s_axi_araddr;
  logic [31:0]         s_axi_wdata;
  logic [31:0]         s_axi_rdata;
  logic [3:0]          s_axi_wstrb;
  logic [1:0]          s_axi_bresp;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready;
  logic [15:0]         seed;
  int                  err_total;
  int                  comparisons;

  sdid_ctrl_model u_ctrl (.i_sys_clk, .i_lvl(lvl), .o_din(i_din));
  sdid_decoder #(.NUM_INPUTS(10), .FULL_VARIANT(1'b1), .SETPOINT_W(16)) dut (
    .i_sys_clk, .i_rstn, .i_din, .i_analog_speed_mag, .i_analog_speed_used, .o_cmd,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // called just after an edge; valids held until their ready is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge i_sys_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge i_sys_clk);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge i_sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge i_sys_clk);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // margin over the model stage plus the input filter
  task automatic pins(input logic [9:0] v);
    lvl <= v;
    repeat (8) @(posedge i_sys_clk);
  endtask

  task automatic ack;
    int n;
    n = 0;
    pins(lvl & ~10'h008);
    lvl <= lvl | 10'h008;
    repeat (12)
    begin
      @(posedge i_sys_clk);
      n += (o_cmd.fault_ack === 1'b1);
    end
    chk(n, 1);
  endtask

  // decode fields only; stop state is judged apart
  function automatic sdid_pkg::sdid_cmd_t exp_cmd(input logic ph, input logic [9:0] d,
                                                  input logic u, input logic [15:0] m);
    sdid_pkg::sdid_cmd_t e;
    e = '0;
    if (!ph)
    begin
      e.gain_high = d[4];
      e.pulse_inhibit = d[5];
      e.droop_clear = d[8];
      e.droop_clear_mode = 2'h2;
      e.gear_ratio = {d[8], d[7]};
      return e;
    end
    e.speed_limit_sel = {d[8], d[7]};
    e.cw_enable = d[4];
    e.cw_ramp_up = d[4];
    e.ccw_enable = d[5];
    e.ccw_ramp_up = !d[5];
    if (d[9])
    begin
      e.torque_fixed = d[8];
      e.active_mode = sdid_pkg::SDID_ACT_TORQUE;
      return e;
    end
    e.gain_high = d[4];
    e.torque_limit_sel = {d[5], d[4]};
    e.zero_clamp = d[7] && u && (m < 16'h0100);
    e.speed_source = {d[7], d[5], d[4]};
    e.active_mode = sdid_pkg::SDID_ACT_SPEED;
    return e;
  endfunction

  task automatic one(input logic ph, input logic [9:0] v);
    sdid_pkg::sdid_cmd_t e;
    pins(v);
    e = exp_cmd(ph, v, i_analog_speed_used, i_analog_speed_mag);
    chk(o_cmd[21:0], e[21:0]);
  endtask

  task automatic rnd(input logic ph);
    logic [9:0] v;
    repeat (12)
    begin
      seed = lfsr(seed);
      i_analog_speed_used <= seed[15];
      i_analog_speed_mag <= {7'h00, seed[14:6]};
      v = {seed[4] & ph, seed[3], seed[2], 1'b1, seed[1], seed[0], 4'h3};
      one(ph, v);
    end
  endtask

  // ********
  // run
  // ********
  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    finish_test;
  end

  initial
  begin
    i_rstn = 1'b0;
    lvl = 10'h000;
    i_analog_speed_mag = 16'h0000;
    i_analog_speed_used = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    seed = 16'h001d;
    err_total = 0;
    comparisons = 0;
    repeat (2) @(posedge i_sys_clk);
    chk(o_cmd, 32'h0000_0000);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    rd(`SDID_ADDR_CONTROL, `SDID_CTL_RST, `SDID_RESP_OKAY);
    rd(`SDID_ADDR_THRESHOLD, `SDID_THR_RST, `SDID_RESP_OKAY);
    rd(`SDID_ADDR_FSEL0, `SDID_FSEL0_RST, `SDID_RESP_OKAY);
    rd(`SDID_ADDR_FSEL1, `SDID_FSEL1_RST, `SDID_RESP_OKAY);
    rd(`SDID_ADDR_FSEL2, `SDID_FSEL2_RST, `SDID_RESP_OKAY);
    rd(8'h1c, 32'h0000_0000, `SDID_RESP_SLVERR);
    rd(`SDID_ADDR_CMD_STATUS, 32'h0080_0000, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_INPUT_STATUS, 32'hffff_ffff, `SDID_RESP_SLVERR);
    wr(`SDID_ADDR_FSEL2, 32'hffff_ffff, `SDID_RESP_OKAY);
    rd(`SDID_ADDR_FSEL2, `SDID_FSEL2_MASK, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_FSEL2, `SDID_FSEL2_RST, `SDID_RESP_OKAY);
    pins(10'h043);
    rd(`SDID_ADDR_INPUT_STATUS, 32'h0000_0043, `SDID_RESP_OKAY);
    chk(o_cmd.quick_stop, 1'b1);
    ack;
    chk(o_cmd.quick_stop, 1'b0);
    pins(10'h047);
    chk(o_cmd.power_on, 1'b1);
    pins(10'h046);
    chk({o_cmd.power_on, o_cmd.quick_stop}, 2'h1);
    pins(10'h047);
    ack;
    pins(10'h007);
    chk({o_cmd.power_on, o_cmd.quick_stop}, 2'h1);
    pins(10'h047);
    ack;
    pins(10'h043);
    chk({o_cmd.ramp_stop, o_cmd.coast_stop}, 2'h2);
    wr(`SDID_ADDR_CONTROL, 32'h0000_0002, `SDID_RESP_OKAY);
    pins(10'h047);
    chk({o_cmd.power_on, o_cmd.ramp_stop}, 2'h2);
    pins(10'h043);
    chk({o_cmd.ramp_stop, o_cmd.coast_stop}, 2'h1);
    wr(`SDID_ADDR_CONTROL, 32'h0000_0020, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_FSEL0, 32'h7854_1032, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_FSEL1, 32'hffff_fff8, `SDID_RESP_OKAY);
    one(1'b0, 10'h1f3);
    rnd(1'b0);
    wr(`SDID_ADDR_CONTROL, 32'h0000_0007, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_THRESHOLD, 32'h0000_0100, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_FSEL1, 32'h7548_7548, `SDID_RESP_OKAY);
    wr(`SDID_ADDR_FSEL2, 32'h0096_8754, `SDID_RESP_OKAY);
    rnd(1'b1);
    // strict compare: the threshold itself must not clamp
    i_analog_speed_used <= 1'b1;
    i_analog_speed_mag <= 16'h0100;
    one(1'b1, 10'h0c3);
    i_analog_speed_mag <= 16'h00ff;
    one(1'b1, 10'h0c3);
    finish_test;
  end
endmodule
`default_nettype wire
